// *** core/der_pkg.sv ***
package der_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL_STATUS = 12'h000;
  localparam logic [11:0] ADDR_PCI_ADDRESS = 12'h004;
  localparam logic [11:0] ADDR_BYTE_COUNT  = 12'h008;
  localparam logic [11:0] ADDR_IRQ_ENABLE  = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_ROUTE   = 12'h010;
  localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h014;
  localparam logic [11:0] ADDR_REMAINING   = 12'h018;

  ////////////////////////////////////////////////////////////////////////////
  // Control/status field positions
  localparam int BIT_GO         = 0;
  localparam int BIT_DIR        = 1;
  localparam int BIT_RST_REQ    = 2;
  localparam int BIT_ACTIVE     = 3;
  localparam int BIT_FLAG_LO    = 4;
  localparam int BIT_CLINE8     = 8;
  localparam int BIT_WMARK_LO   = 16;

  // Event index, shared by flags, enables, routes and pending bits
  localparam int EV_DONE        = 0;
  localparam int EV_PCI_ERR     = 1;
  localparam int EV_LOCAL_ERR   = 2;
  localparam int EV_RESET       = 3;
  localparam int EV_NUM         = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Widths, depths and values after reset
  localparam int LEVEL_W        = 7;
  localparam int COUNT_W        = 24;
  localparam int WMARK_W        = 8;
  localparam logic [LEVEL_W-1:0] FIFO_DEPTH_WORDS = 7'h40;
  localparam logic [LEVEL_W-1:0] CACHELINE_SIZE_SHORT      = 7'h04;
  localparam logic [LEVEL_W-1:0] CACHELINE_SIZE_LONG       = 7'h08;
  localparam logic [COUNT_W-1:0] WORD_BYTES       = 24'h000004;
  localparam logic [EV_NUM-1:0]  RST_IRQ_ENABLE   = 4'h0;
  localparam logic [EV_NUM-1:0]  RST_IRQ_ROUTE    = 4'h0;
  localparam logic [WMARK_W-1:0] RST_WMARK        = 8'h00;
  localparam logic [31:0]        RST_PCI_ADDRESS  = 32'h0000_0000;
  localparam logic [COUNT_W-1:0] RST_BYTE_COUNT   = 24'h000000;
  localparam int SYNC_STAGES    = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Channel states
  typedef enum logic [2:0] {
    DER_IDLE,
    DER_RUN,
    DER_LFILL,
    DER_HALT,
    DER_RST_WAIT,
    DER_RST_FLUSH
  } der_state_e;

endpackage

// *** core/der_sync.sv ***
`timescale 1ns/1ps
module der_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Asynchronous level in, filtered level out
  input  wire logic async_i,
  output logic      level_o
);
  import der_pkg::*;

  typedef struct packed {
    logic [SYNC_STAGES-1:0] stage;
    logic                   level;
  } der_sync_s;

  der_sync_s r;
  der_sync_s next_r;

  // First stage feeds only the second; change taken once stages two and three agree
  always_comb begin
    next_r       = r;
    next_r.stage = {r.stage[SYNC_STAGES-2:0], async_i};
    if (r.stage[1] == r.stage[2]) begin
      next_r.level = r.stage[2];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign level_o = r.level;
endmodule

// *** core/der_flag.sv ***
`timescale 1ns/1ps
module der_flag (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Hardware set, software write-one clear
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);
  import der_pkg::*;

  typedef struct packed {
    logic flag;
  } der_flag_s;

  der_flag_s r;
  der_flag_s next_r;

  // A set in the clearing cycle wins
  always_comb begin
    next_r = r;
    if (set_i) begin
      next_r.flag = 1'b1;
    end else if (clr_i) begin
      next_r.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign flag_o = r.flag;
endmodule

// *** core/der_top.sv ***
// Operation
// RULE1: PCI error sets the PCI error flag
// RULE2: Local bus error sets the local error flag
// RULE3: Local error on write: fill to watermark first
// RULE4: PCI read error: stop prefetch, flag, drop request
// RULE5: Local read error: drop request, flag, finish prefetch
// RULE6: PCI write error: halt writes, flag, drop request
// RULE7: Local write error: drop request, send complete cachelines
// RULE8: Four events each have an interrupt enable
// RULE9: Each event routed to PCI or local pin
// RULE10: Readable pending status for each event
// RULE11: Flags cleared by writing one; clears interrupt
// RULE12: Halted transfer resumes only after channel reset
// RULE13: Reset-done flag set when channel reset finishes
// RULE14: Errors leave the local slave channel untouched
// RULE15: Reset request ignored while channel inactive
// RULE16: Active reset first drops the DMA request; code drops it in the same cycle as prefetch off and the stops
// RULE17: Reset ends write at cacheline, read at once
// RULE18: FIFO flushed only after frame has ended
// RULE19: Reset clears active, keeps address and count
// RULE20: Reset interrupt raised on routed pin if enabled
// RULE21: Done flag set when byte count expires
// RULE22: Active bit held through the whole transfer
// RULE23: Pin asserted by any enabled pending routed event
`timescale 1ns/1ps
module der_top (
  // Clock and reset
  input  wire logic                         CLK_SYS_I,
  input  wire logic                         ARST_N_I,
  // APB slave
  input  wire logic                         PSEL_I,
  input  wire logic                         PENABLE_I,
  input  wire logic                         PWRITE_I,
  input  wire logic [11:0]                  PADDR_I,
  input  wire logic [31:0]                  PWDATA_I,
  output logic      [31:0]                  PRDATA_O,
  output logic                              PREADY_O,
  output logic                              PSLVERR_O,
  // Local bus DMA handshake pins
  input  wire logic                         LOCAL_ERR_I,
  output logic                              DMA_REQUEST_N_O,
  // PCI master and shared FIFO
  input  wire logic                         PCI_ERR_I,
  input  wire logic                         PCI_FRAME_I,
  input  wire logic                         PCI_WORD_I,
  input  wire logic [der_pkg::LEVEL_W-1:0]  FIFO_LEVEL_I,
  output logic                              PCI_PREFETCH_EN_O,
  output logic                              PCI_WRITE_EN_O,
  output logic                              PCI_STOP_NOW_O,
  output logic                              PCI_STOP_CACHELINE_SIZE_O,
  output logic                              FIFO_FLUSH_O,
  // Interrupt pins
  output logic                              INT_PCI_O,
  output logic                              INT_LOCAL_O
);
  import der_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    der_state_e           state;
    logic                 dir;
    logic                 cline8;
    logic [WMARK_W-1:0]   wmark;
    logic [31:0]          pci_addr;
    logic [COUNT_W-1:0]   byte_cnt;
    logic [COUNT_W-1:0]   remain;
    logic [EV_NUM-1:0]    irq_en;
    logic [EV_NUM-1:0]    irq_route;
    logic                 req_n;
    logic                 prefetch;
    logic                 wr_en;
    logic                 stop_now;
    logic                 stop_cacheline_size;
    logic                 flush;
    logic                 int_pci;
    logic                 int_local;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
  } der_top_s;

  der_top_s            r;
  der_top_s            next_r;
  logic [1:0]          rst_pipe;
  logic                rst_n;
  logic                local_err;
  logic [EV_NUM-1:0]   flags;
  logic [EV_NUM-1:0]   flag_set;
  logic [EV_NUM-1:0]   flag_clr;
  logic [EV_NUM-1:0]   pending;
  logic                wr_access;
  logic                cs_write;
  logic                active;
  logic [LEVEL_W-1:0]  cacheline_size_words;
  logic [LEVEL_W-1:0]  fill_target;
  logic                mapped;
  logic [31:0]         rd_value;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  ////////////////////////////////////////////////////////////////////////////
  // Local bus error pin

  der_sync u_local_err_sync (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (rst_n),
    .async_i (LOCAL_ERR_I),
    .level_o (local_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event flags

  // RULE11: write one clears
  assign flag_clr = cs_write ? PWDATA_I[BIT_FLAG_LO +: EV_NUM] : 4'h0;

  for (genvar i = 0; i < EV_NUM; i++) begin : g_flag
    der_flag u_flag (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_n),
      .set_i   (flag_set[i]),
      .clr_i   (flag_clr[i]),
      .flag_o  (flags[i])
    );
  end

  // RULE10: pending per source
  assign pending = flags & r.irq_en;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  assign wr_access   = PSEL_I && PENABLE_I && PWRITE_I && r.pready && !r.pslverr;
  assign cs_write    = wr_access && (PADDR_I == ADDR_CTRL_STATUS);
  // RULE22: active from go to done or reset
  assign active      = (r.state != DER_IDLE);
  assign cacheline_size_words = r.cline8 ? CACHELINE_SIZE_LONG : CACHELINE_SIZE_SHORT;
  assign fill_target = (r.wmark == RST_WMARK) ? cacheline_size_words : r.wmark[LEVEL_W-1:0];

  always_comb begin
    mapped   = 1'b1;
    rd_value = 32'h0000_0000;
    unique case (PADDR_I)
      ADDR_CTRL_STATUS: begin
        rd_value[BIT_DIR]                     = r.dir;
        rd_value[BIT_ACTIVE]                  = active;
        rd_value[BIT_FLAG_LO +: EV_NUM]       = flags;
        rd_value[BIT_CLINE8]                  = r.cline8;
        rd_value[BIT_WMARK_LO +: WMARK_W]     = r.wmark;
      end
      ADDR_PCI_ADDRESS: rd_value = r.pci_addr;
      ADDR_BYTE_COUNT:  rd_value[COUNT_W-1:0] = r.byte_cnt;
      ADDR_IRQ_ENABLE:  rd_value[EV_NUM-1:0]  = r.irq_en;
      ADDR_IRQ_ROUTE:   rd_value[EV_NUM-1:0]  = r.irq_route;
      ADDR_IRQ_STATUS:  rd_value[EV_NUM-1:0]  = pending;
      ADDR_REMAINING:   rd_value[COUNT_W-1:0] = r.remain;
      default:          mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_r   = r;
    flag_set = 4'h0;

    // APB: zero-wait answer in the first access cycle
    next_r.pready  = PSEL_I && !PENABLE_I;
    next_r.pslverr = PSEL_I && !PENABLE_I && !mapped;
    if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      next_r.prdata = rd_value;
    end

    // RULE8: enables; RULE9: routes
    if (wr_access && PADDR_I == ADDR_IRQ_ENABLE) begin
      next_r.irq_en = PWDATA_I[EV_NUM-1:0];
    end
    if (wr_access && PADDR_I == ADDR_IRQ_ROUTE) begin
      next_r.irq_route = PWDATA_I[EV_NUM-1:0];
    end
    // RULE19: address, count and setup only change by software
    if (!active && cs_write) begin
      next_r.dir    = PWDATA_I[BIT_DIR];
      next_r.cline8 = PWDATA_I[BIT_CLINE8];
      next_r.wmark  = PWDATA_I[BIT_WMARK_LO +: WMARK_W];
    end
    if (!active && wr_access && PADDR_I == ADDR_PCI_ADDRESS) begin
      next_r.pci_addr = PWDATA_I;
    end
    if (!active && wr_access && PADDR_I == ADDR_BYTE_COUNT) begin
      next_r.byte_cnt = PWDATA_I[COUNT_W-1:0];
    end

    next_r.flush = 1'b0;

    unique case (r.state)
      DER_IDLE: begin
        next_r.req_n      = 1'b1;
        next_r.prefetch   = 1'b0;
        next_r.wr_en      = 1'b0;
        next_r.stop_now   = 1'b0;
        next_r.stop_cacheline_size = 1'b0;
        // RULE15: reset request has no effect here
        if (cs_write && PWDATA_I[BIT_GO]) begin
          next_r.state  = DER_RUN;
          next_r.remain = next_r.byte_cnt;
        end
      end

      DER_RUN, DER_LFILL: begin
        if (next_r.dir) begin
          next_r.req_n = !(FIFO_LEVEL_I < FIFO_DEPTH_WORDS);
          next_r.wr_en = 1'b1;
        end else begin
          next_r.req_n    = (FIFO_LEVEL_I == 7'h00);
          next_r.prefetch = 1'b1;
        end
        if (PCI_WORD_I && r.remain != 24'h000000) begin
          next_r.remain = r.remain - WORD_BYTES;
        end
        if (r.remain == 24'h000000 ||
            (PCI_WORD_I && r.remain <= WORD_BYTES)) begin
          // RULE21: count expired
          flag_set[EV_DONE] = 1'b1;
          next_r.state      = DER_IDLE;
          next_r.req_n      = 1'b1;
          next_r.prefetch   = 1'b0;
          next_r.wr_en      = 1'b0;
        end else if (PCI_ERR_I) begin
          // RULE1: PCI error flagged
          flag_set[EV_PCI_ERR] = 1'b1;
          next_r.state         = DER_HALT;
          if (r.dir) begin
            // RULE6: writes halted, request dropped at once
            next_r.wr_en = 1'b0;
            next_r.req_n = 1'b1;
          end else begin
            // RULE4: prefetch off now, request drops a cycle later
            next_r.prefetch = 1'b0;
            next_r.req_n    = r.req_n;
          end
        end else if (r.state == DER_RUN && local_err && !r.dir) begin
          // RULE2: local error flagged
          // RULE5: request off, prefetch runs out with the frame
          flag_set[EV_LOCAL_ERR] = 1'b1;
          next_r.state           = DER_HALT;
          next_r.req_n           = 1'b1;
          next_r.prefetch        = r.prefetch && PCI_FRAME_I;
        end else if (r.state == DER_RUN && local_err) begin
          // RULE3: keep filling up to the watermark
          next_r.state = DER_LFILL;
        end else if (r.state == DER_LFILL && FIFO_LEVEL_I >= fill_target) begin
          // RULE7: request off, whole cachelines still drain
          flag_set[EV_LOCAL_ERR] = 1'b1;
          next_r.state           = DER_HALT;
          next_r.req_n           = 1'b1;
          next_r.wr_en           = PCI_FRAME_I && FIFO_LEVEL_I >= cacheline_size_words;
        end
      end

      DER_HALT: begin
        // RULE12: stays halted until a reset request
        next_r.req_n    = 1'b1;
        next_r.prefetch = r.prefetch && PCI_FRAME_I;
        next_r.wr_en    = r.wr_en && PCI_FRAME_I && FIFO_LEVEL_I >= cacheline_size_words;
      end

      DER_RST_WAIT: begin
        next_r.req_n = 1'b1;
        // RULE18: flush once the frame is gone
        if (!PCI_FRAME_I) begin
          next_r.stop_now   = 1'b0;
          next_r.stop_cacheline_size = 1'b0;
          next_r.wr_en      = 1'b0;
          next_r.flush      = 1'b1;
          next_r.state      = DER_RST_FLUSH;
        end
      end

      DER_RST_FLUSH: begin
        // RULE13: reset finished
        // RULE19: active clears, reset flag sets
        // RULE20: reset event feeds the routed pin
        flag_set[EV_RESET] = 1'b1;
        next_r.state       = DER_IDLE;
      end
    endcase

    // RULE16: request dropped at once, in the same cycle as prefetch off and the stops
    // RULE17: write ends at cacheline, read at once
    if (cs_write && PWDATA_I[BIT_RST_REQ] &&
        (r.state == DER_RUN || r.state == DER_LFILL || r.state == DER_HALT)) begin
      next_r.state      = DER_RST_WAIT;
      next_r.req_n      = 1'b1;
      next_r.prefetch   = 1'b0;
      next_r.wr_en      = r.dir && PCI_FRAME_I && r.wr_en;
      next_r.stop_cacheline_size = r.dir && PCI_FRAME_I;
      next_r.stop_now   = !r.dir && PCI_FRAME_I;
    end

    // RULE14: only this channel's pins are touched by errors
    // RULE23: pin is the OR of routed pending events
    next_r.int_pci   = |(flags & r.irq_en & r.irq_route);
    next_r.int_local = |(flags & r.irq_en & ~r.irq_route);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      r            <= '0;
      r.state      <= DER_IDLE;
      r.wmark      <= RST_WMARK;
      r.pci_addr   <= RST_PCI_ADDRESS;
      r.byte_cnt   <= RST_BYTE_COUNT;
      r.irq_en     <= RST_IRQ_ENABLE;
      r.irq_route  <= RST_IRQ_ROUTE;
      r.req_n      <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign PRDATA_O          = r.prdata;
  assign PREADY_O          = r.pready;
  assign PSLVERR_O         = r.pslverr;
  assign DMA_REQUEST_N_O   = r.req_n;
  assign PCI_PREFETCH_EN_O = r.prefetch;
  assign PCI_WRITE_EN_O    = r.wr_en;
  assign PCI_STOP_NOW_O    = r.stop_now;
  assign PCI_STOP_CACHELINE_SIZE_O  = r.stop_cacheline_size;
  assign FIFO_FLUSH_O      = r.flush;
  assign INT_PCI_O         = r.int_pci;
  assign INT_LOCAL_O       = r.int_local;

endmodule

// *** bench/der_far.sv ***
`timescale 1ns/1ps
module der_far (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  // Bench controls
  input  wire logic                        dir_i,
  input  wire logic                        slow_i,
  // Channel controls from the block
  input  wire logic                        req_n_i,
  input  wire logic                        prefetch_i,
  input  wire logic                        write_en_i,
  input  wire logic                        stop_now_i,
  input  wire logic                        stop_cacheline_size_i,
  input  wire logic                        flush_i,
  // PCI master and FIFO state
  output logic                             frame_o,
  output logic                             word_o,
  output logic [der_pkg::LEVEL_W-1:0]      level_o
);
  import der_pkg::*;
  logic tick;
  logic pci_mv;
  logic loc_mv;

  // Slow mode lets the PCI side move one word every other cycle
  always_comb begin
    pci_mv = frame_o && (!slow_i || tick);
    loc_mv = !req_n_i && (dir_i ? (level_o < FIFO_DEPTH_WORDS) : (level_o != '0));
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick    <= 1'b0;
      frame_o <= 1'b0;
      word_o  <= 1'b0;
      level_o <= '0;
    end else begin
      tick   <= !tick;
      word_o <= pci_mv;
      // Writes start on a full cacheline, reads stop short of full
      if (dir_i) begin
        frame_o <= write_en_i && !stop_cacheline_size_i && level_o >= CACHELINE_SIZE_SHORT;
      end else begin
        frame_o <= prefetch_i && !stop_now_i && level_o < 7'h3C;
      end
      if (flush_i) begin
        level_o <= '0;
      end else if (dir_i) begin
        level_o <= level_o + {6'h00, loc_mv} - {6'h00, pci_mv};
      end else begin
        level_o <= level_o + {6'h00, pci_mv} - {6'h00, loc_mv};
      end
    end
  end
endmodule

// *** bench/der_sva.sv ***
`timescale 1ns/1ps
module der_sva (
  // Clock, reset and APB
  input wire logic        CLK_SYS_I,
  input wire logic        ARST_N_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  // Channel
  input wire logic        PCI_ERR_I,
  input wire logic        PCI_FRAME_I,
  input wire logic        DMA_REQUEST_N_O,
  input wire logic        PCI_PREFETCH_EN_O,
  input wire logic        PCI_WRITE_EN_O,
  input wire logic        PCI_STOP_NOW_O,
  input wire logic        PCI_STOP_CACHELINE_SIZE_O,
  input wire logic        FIFO_FLUSH_O,
  input wire logic        INT_PCI_O,
  input wire logic        INT_LOCAL_O
);
  default clocking dcb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!ARST_N_I);

  apb_answer_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O)
    else $error("access not answered in one cycle");
  unmapped_err_a: assert property (PSEL_I && !PENABLE_I && PADDR_I > 12'h018
    |=> PSLVERR_O && PREADY_O) else $error("unmapped access not refused");
  err_read_zero_a: assert property (PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0000_0000)
    else $error("refused read returned data");
  pci_wr_halt_a: assert property (
    PCI_ERR_I && PCI_WRITE_EN_O |=> !PCI_WRITE_EN_O && DMA_REQUEST_N_O)
    else $error("write not halted on PCI error");
  pci_rd_stop_a: assert property (
    PCI_ERR_I && PCI_PREFETCH_EN_O |=> !PCI_PREFETCH_EN_O ##1 DMA_REQUEST_N_O)
    else $error("read error order wrong");
  stop_req_a: assert property (
    PCI_STOP_NOW_O || PCI_STOP_CACHELINE_SIZE_O |-> DMA_REQUEST_N_O && !PCI_PREFETCH_EN_O)
    else $error("request kept during reset");
  stop_flush_a: assert property (
    (PCI_STOP_NOW_O || PCI_STOP_CACHELINE_SIZE_O) && !PCI_FRAME_I |=> FIFO_FLUSH_O)
    else $error("no flush after frame ended");
  flush_frame_a: assert property (FIFO_FLUSH_O |-> !$past(PCI_FRAME_I))
    else $error("flush while frame open");
  flush_pulse_a: assert property (FIFO_FLUSH_O |=> !FIFO_FLUSH_O [*2])
    else $error("flush longer than one cycle");

  cover property ($rose(INT_PCI_O));
  cover property ($rose(INT_LOCAL_O));
  cover property (FIFO_FLUSH_O);
  cover property (PSLVERR_O);
endmodule

bind der_top der_sva u_sva (.*);

// *** bench/der_top_tb.sv ***
`timescale 1ns/1ps
module der_top_tb;
  import der_pkg::*;
  logic                 CLK_SYS_I, ARST_N_I, PSEL_I, PENABLE_I, PWRITE_I, PSLVERR_O;
  logic                 LOCAL_ERR_I, PCI_ERR_I, PCI_FRAME_I, PCI_WORD_I, PREADY_O;
  logic [11:0]          PADDR_I;
  logic [31:0]          PWDATA_I, PRDATA_O, q;
  logic [LEVEL_W-1:0]   FIFO_LEVEL_I;
  logic                 DMA_REQUEST_N_O, PCI_PREFETCH_EN_O, PCI_WRITE_EN_O, FIFO_FLUSH_O;
  logic                 PCI_STOP_NOW_O, PCI_STOP_CACHELINE_SIZE_O, INT_PCI_O, INT_LOCAL_O;
  logic                 dir, slow, e;
  int                   failures = 0, n_compared = 0, cycles = 0;

  der_top dut (.*);
  der_far far (
    .clk_i(CLK_SYS_I), .rst_n_i(ARST_N_I), .dir_i(dir), .slow_i(slow),
    .req_n_i(DMA_REQUEST_N_O), .prefetch_i(PCI_PREFETCH_EN_O), .write_en_i(PCI_WRITE_EN_O),
    .stop_now_i(PCI_STOP_NOW_O), .stop_cacheline_size_i(PCI_STOP_CACHELINE_SIZE_O), .flush_i(FIFO_FLUSH_O),
    .frame_o(PCI_FRAME_I), .word_o(PCI_WORD_I), .level_o(FIFO_LEVEL_I)
  );

  initial begin
    CLK_SYS_I = 1'b0;
    forever #20 CLK_SYS_I = ~CLK_SYS_I;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge CLK_SYS_I) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL_I   <= 1'b1;
    PWRITE_I <= w;
    PADDR_I  <= a;
    PWDATA_I <= d;
    @(posedge CLK_SYS_I);
    PENABLE_I <= 1'b1;
    do begin
      @(posedge CLK_SYS_I);
    end while (PREADY_O !== 1'b1);
    q = PRDATA_O;
    e = PSLVERR_O;
    PSEL_I    <= 1'b0;
    PENABLE_I <= 1'b0;
    // Idle edge so the next setup never re-raises select in this step
    @(posedge CLK_SYS_I);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic wait_cs(input logic [31:0] m);
    do begin
      apb(1'b0, ADDR_CTRL_STATUS, 32'h0);
    end while ((q & m) == 32'h0);
  endtask

  task automatic go(input logic dr, input logic [31:0] route);
    dir <= dr;
    apb(1'b1, ADDR_IRQ_ROUTE, route);
    apb(1'b1, ADDR_BYTE_COUNT, 32'h0000_1000);
    apb(1'b1, ADDR_CTRL_STATUS, {30'h0, dr, 1'b1});
    repeat (20) @(posedge CLK_SYS_I);
  endtask

  task automatic ch_reset(input logic [31:0] exp);
    apb(1'b1, ADDR_CTRL_STATUS, 32'h0000_0004);
    wait_cs(32'h0000_0080);
    chk(q, exp);
    chk(32'(INT_PCI_O | INT_LOCAL_O), 32'h1);
    rd(ADDR_BYTE_COUNT, 32'h0000_1000);
    rd(ADDR_PCI_ADDRESS, 32'h1234_5670);
    apb(1'b1, ADDR_CTRL_STATUS, 32'h0000_00F0);
    repeat (2) @(posedge CLK_SYS_I);
    chk(32'(INT_PCI_O | INT_LOCAL_O), 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(ADDR_CTRL_STATUS, 32'h0);
    rd(ADDR_IRQ_STATUS, 32'h0);
    apb(1'b0, 12'h01C, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    apb(1'b1, ADDR_PCI_ADDRESS, 32'h1234_5670);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_000F);
    rd(ADDR_IRQ_ENABLE, 32'h0000_000F);
  endtask

  task automatic t_idle_reset();
    apb(1'b1, ADDR_CTRL_STATUS, 32'h0000_0004);
    repeat (8) @(posedge CLK_SYS_I);
    rd(ADDR_CTRL_STATUS, 32'h0);
  endtask

  task automatic t_done();
    dir <= 1'b1;
    apb(1'b1, ADDR_IRQ_ROUTE, 32'h1);
    apb(1'b1, ADDR_BYTE_COUNT, 32'h20);
    apb(1'b1, ADDR_CTRL_STATUS, 32'h3);
    rd(ADDR_CTRL_STATUS, 32'hA);
    wait_cs(32'h10);
    chk(q, 32'h12);
    chk(32'({INT_PCI_O, INT_LOCAL_O}), 32'h2);
    rd(ADDR_IRQ_STATUS, 32'h1);
    rd(ADDR_IRQ_ROUTE, 32'h1);
    rd(ADDR_REMAINING, 32'h0);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'hE);
    repeat (2) @(posedge CLK_SYS_I);
    chk(32'(INT_PCI_O), 32'h0);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'hF);
    apb(1'b1, ADDR_CTRL_STATUS, 32'h12);
    repeat (2) @(posedge CLK_SYS_I);
    chk(32'({INT_PCI_O, INT_LOCAL_O}), 32'h0);
  endtask

  task automatic t_pci_wr_err();
    go(1'b1, 32'h0);
    PCI_ERR_I <= 1'b1;
    @(posedge CLK_SYS_I);
    PCI_ERR_I <= 1'b0;
    repeat (2) @(posedge CLK_SYS_I);
    chk(32'({DMA_REQUEST_N_O, PCI_WRITE_EN_O}), 32'h2);
    rd(ADDR_CTRL_STATUS, 32'h2A);
    chk(32'(INT_LOCAL_O), 32'h1);
    apb(1'b1, ADDR_CTRL_STATUS, 32'h20);
    repeat (4) @(posedge CLK_SYS_I);
    chk(32'({DMA_REQUEST_N_O, INT_LOCAL_O}), 32'h2);
    rd(ADDR_CTRL_STATUS, 32'hA);
    ch_reset(32'h82);
  endtask

  task automatic t_loc_err(input logic dr);
    slow <= 1'b1;
    go(dr, {28'h0, {4{!dr}}});
    LOCAL_ERR_I <= 1'b1;
    repeat (6) @(posedge CLK_SYS_I);
    LOCAL_ERR_I <= 1'b0;
    wait_cs(32'h40);
    chk(q, {30'h0, dr, 1'b0} | 32'h48);
    chk(32'(DMA_REQUEST_N_O), 32'h1);
    ch_reset({30'h30, dr, 1'b0});
    slow <= 1'b0;
  endtask

  task automatic t_pci_rd_err();
    go(1'b0, 32'hF);
    PCI_ERR_I <= 1'b1;
    @(posedge CLK_SYS_I);
    PCI_ERR_I <= 1'b0;
    repeat (3) @(posedge CLK_SYS_I);
    chk(32'({DMA_REQUEST_N_O, PCI_PREFETCH_EN_O}), 32'h2);
    rd(ADDR_CTRL_STATUS, 32'h28);
    chk(32'(INT_PCI_O), 32'h1);
    ch_reset(32'hA0);
  endtask

  initial begin
    ARST_N_I = 1'b0;
    {PSEL_I, PENABLE_I, PWRITE_I, LOCAL_ERR_I, PCI_ERR_I, dir, slow} = 7'h00;
    PADDR_I = 12'h000;
    PWDATA_I = 32'h0;
    repeat (16) @(posedge CLK_SYS_I);
    ARST_N_I <= 1'b1;
    repeat (4) @(posedge CLK_SYS_I);
    t_regs();
    t_idle_reset();
    t_done();
    t_pci_wr_err();
    t_loc_err(1'b1);
    t_pci_rd_err();
    t_loc_err(1'b0);
    complete_run();
  end
endmodule
